// ### seq_top.sv
// Self-test sequencer: control state machine, pattern generator, address swap and AXI4-Lite registers.
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "seq_cfg.svh"

module seq_top #(
    parameter bit avb_present = 1'b0,
    parameter logic [47:0] gen_destination_address = 48'h020000000002,
    parameter logic [47:0] gen_source_address = 48'h020000000001,
    parameter logic [10:0] gen_min_size = 11'h02e,
    parameter logic [10:0] gen_max_size = 11'h05dc,
    parameter bit gen_tag_insert_on = 1'b0,
    parameter logic [11:0] gen_tag_identifier = 12'h001,
    parameter logic [2:0] gen_tag_priority = 3'h0
) (
    // Clock, reset and enable.
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // Link clock pin, paces the byte stream.
    input wire logic link_clk,
    // Received byte stream from the MAC.
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_last,
    // Byte stream back to the MAC transmitter.
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic tx_last,
    // Management bus requests.
    output logic mgmt_rd_req,
    output logic mgmt_wr_req,
    output logic [4:0] phy_bus_address,
    input wire logic mgmt_rd_valid,
    input wire logic [15:0] mgmt_rd_data,
    // Timing frame handshake.
    output logic ptp_tx_req,
    input wire logic ptp_rx_seen,
    // Interrupt.
    output logic irq,
    // AXI4-Lite slave.
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    import seq_pkg::*;

    // ----------------------------------------
    // Generator frame layout
    // ----------------------------------------
    localparam int HDR = gen_tag_insert_on ? 16 : 12; // Bytes before the length field.
    localparam logic [31:0] TAG = {16'h8100, gen_tag_priority, 1'b0, gen_tag_identifier};

    seq_regs_t s_r; // Registered state.
    seq_regs_t s_nxt; // Next state.
    logic tick; // Rising edge seen on the link clock.
    logic gen_go; // Generator owns the stream.
    logic gen_last; // Generator is at its final byte.
    logic [7:0] gen_b; // Generator byte at the current index.
    logic [9:0] entry; // Byte entering the swap line.

    // Byte of a generated frame: addresses, optional tag, length, then a falling count.
    function automatic logic [7:0] gen_byte(input logic [10:0] i, input logic [10:0] len);
        int k;
        logic [10:0] d;
        k = int'(i);
        d = len - (i - 11'(HDR + 2));
        if (k < 6) gen_byte = gen_destination_address[8 * (5 - k) +: 8];
        else if (k < 12) gen_byte = gen_source_address[8 * (11 - k) +: 8];
        else if (k < HDR) gen_byte = TAG[8 * (15 - k) +: 8];
        else if (k == HDR) gen_byte = {5'h00, len[10:8]};
        else if (k == HDR + 1) gen_byte = len[7:0];
        else gen_byte = d[7:0];
    endfunction

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    // Everything is computed here; the clocked process only registers it.
    always_comb begin
        s_nxt = s_r;
        s_nxt.mgmt_rd_req = 1'b0;
        s_nxt.mgmt_wr_req = 1'b0;
        s_nxt.ptp_tx_req = 1'b0;
        s_nxt.tx_valid = 1'b0;
        // Two flops before the edge detector; lk1 feeds only lk2.
        s_nxt.lk1 = link_clk;
        s_nxt.lk2 = s_r.lk1;
        s_nxt.lk3 = s_r.lk2;
        tick = s_r.lk2 & ~s_r.lk3;
        gen_go = (s_r.st == ST_RUN) && s_r.gen_en && s_r.self_test;
        gen_last = int'(s_r.gen_idx) == HDR + 1 + int'(s_r.gen_len);
        gen_b = gen_byte(s_r.gen_idx, s_r.gen_len);
        entry = {rx_valid, rx_last, rx_data};

        // Write channel: address and data are taken in either order.
        if (s_r.awready && awvalid) begin
            s_nxt.awready = 1'b0;
            s_nxt.aw_addr = awaddr;
        end
        if (s_r.wready && wvalid) begin
            s_nxt.wready = 1'b0;
            s_nxt.w_data = wdata;
            s_nxt.w_lane0 = wstrb[0];
        end
        if (!s_r.awready && !s_r.wready && !s_r.bvalid) begin
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = `RESP_OKAY;
            unique case (s_r.aw_addr)
                `OFF_CTRL: begin
                    if (s_r.w_lane0) begin
                        s_nxt.self_test = s_r.w_data[`CTRL_SELF_TEST];
                        s_nxt.swap_en = s_r.w_data[`CTRL_SWAP];
                        s_nxt.gen_en = s_r.w_data[`CTRL_GEN];
                        // Restart rereads the PHY and replays the whole bring-up.
                        if (s_r.w_data[`CTRL_RESTART]) begin
                            s_nxt.st = ST_IDLE;
                            s_nxt.settle = 8'(`SETTLE_CYC);
                        end
                    end
                end
                `OFF_IRQ_MASK: begin
                    if (s_r.w_lane0) s_nxt.mask = s_r.w_data[2:0];
                end
                `OFF_STATUS, `OFF_IRQ_STS, `OFF_FRAMES: begin
                    s_nxt.bresp = `RESP_OKAY;
                end
                default: begin
                    s_nxt.bresp = `RESP_SLVERR;
                end
            endcase
        end
        if (s_r.bvalid && bready) begin
            s_nxt.bvalid = 1'b0;
            s_nxt.awready = 1'b1;
            s_nxt.wready = 1'b1;
        end

        // Read channel; a read of the event register clears it before new events land.
        if (s_r.arready && arvalid) begin
            s_nxt.arready = 1'b0;
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = `RESP_OKAY;
            unique case (araddr)
                `OFF_CTRL: s_nxt.rdata = {28'h0000000, 1'b0, s_r.gen_en, s_r.swap_en, s_r.self_test};
                `OFF_STATUS: s_nxt.rdata = {24'h000000, s_r.ptp_seen, s_r.ptp_sent, s_r.phy_absent, s_r.st};
                `OFF_IRQ_STS: begin
                    s_nxt.rdata = {29'h0000000, s_r.irq_sts};
                    s_nxt.irq_sts = 3'h0;
                end
                `OFF_IRQ_MASK: s_nxt.rdata = {29'h0000000, s_r.mask};
                `OFF_FRAMES: s_nxt.rdata = {16'h0000, s_r.frames};
                default: begin
                    s_nxt.rdata = 32'h00000000;
                    s_nxt.rresp = `RESP_SLVERR;
                end
            endcase
        end
        if (s_r.rvalid && rready) begin
            s_nxt.rvalid = 1'b0;
            s_nxt.arready = 1'b1;
        end

        // Control sequence: settle, probe the PHY, exchange timing frames if self_test and avb_present, then run.
        unique case (s_r.st)
            ST_IDLE: begin
                if (s_r.settle == 8'h00) s_nxt.st = ST_MDIO_RD;
                else s_nxt.settle = s_r.settle - 8'h01;
            end
            ST_MDIO_RD: begin
                s_nxt.mgmt_rd_req = 1'b1;
                s_nxt.st = ST_MDIO_WAIT;
            end
            ST_MDIO_WAIT: begin
                if (mgmt_rd_valid) begin
                    // All ones means nobody answers, so no PHY setup writes follow.
                    s_nxt.phy_absent = (mgmt_rd_data == `PHY_NONE);
                    s_nxt.mgmt_wr_req = (mgmt_rd_data != `PHY_NONE);
                    s_nxt.irq_sts[`IRQ_PHY] = 1'b1;
                    s_nxt.ptp_sent = 2'h0;
                    s_nxt.ptp_seen = 2'h0;
                    s_nxt.st = (s_r.self_test && avb_present) ? ST_PTP_REQ : ST_RUN;
                end
            end
            ST_PTP_REQ: begin
                s_nxt.ptp_tx_req = 1'b1;
                s_nxt.ptp_sent = s_r.ptp_sent + 2'h1;
                if (s_r.ptp_sent + 2'h1 == `PTP_FRAMES) s_nxt.st = ST_PTP_WAIT;
            end
            ST_PTP_WAIT: begin
                if (ptp_rx_seen) begin
                    s_nxt.ptp_seen = s_r.ptp_seen + 2'h1;
                    // Pattern traffic waits until both timing frames came back.
                    if (s_r.ptp_seen + 2'h1 == `PTP_FRAMES) begin
                        s_nxt.st = ST_RUN;
                        s_nxt.irq_sts[`IRQ_PTP] = 1'b1;
                    end
                end
            end
            ST_RUN: begin
                // Stays put; a restart decoded above has already chosen the idle state.
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase

        // One byte moves per rising link clock edge, generator or looped traffic alike.
        if (tick) begin
            if (gen_go) begin
                if (s_r.gen_gap != 4'h0) begin
                    s_nxt.gen_gap = s_r.gen_gap - 4'h1;
                    entry = 10'h000;
                end else begin
                    // Clean frames only: no error path exists in the generator.
                    entry = {1'b1, gen_last, gen_b};
                    s_nxt.gen_idx = s_r.gen_idx + 11'h001;
                    if (gen_last) begin
                        s_nxt.gen_idx = 11'h000;
                        s_nxt.gen_gap = `IFG_TICKS;
                        s_nxt.gen_len = (s_r.gen_len >= gen_max_size) ? gen_min_size
                                      : s_r.gen_len + 11'h001;
                        s_nxt.frames = s_r.frames + 16'h0001;
                        s_nxt.irq_sts[`IRQ_FRAME] = 1'b1;
                    end
                end
            end
            // Stage 11 leaves; stage 5 is six bytes younger, stage 17 six older.
            s_nxt.tx_valid = s_r.sr[11][9];
            s_nxt.tx_last = s_r.sr[11][8];
            if (s_r.swap_en && s_r.out_cnt < 4'h6) s_nxt.tx_data = s_r.sr[5][7:0];
            else if (s_r.swap_en && s_r.out_cnt < 4'hc) s_nxt.tx_data = s_r.sr[17][7:0];
            else s_nxt.tx_data = s_r.sr[11][7:0];
            if (s_r.sr[11][9]) begin
                if (s_r.sr[11][8]) s_nxt.out_cnt = 4'h0;
                else if (s_r.out_cnt < 4'hc) s_nxt.out_cnt = s_r.out_cnt + 4'h1;
            end else begin
                // An empty slot ends any frame, so a cut frame cannot skew the next swap.
                s_nxt.out_cnt = 4'h0;
            end
            s_nxt.sr = {s_r.sr[16:0], entry};
        end

        s_nxt.irq = |(s_nxt.irq_sts & s_nxt.mask);

        // Synchronous reset; the mode follows the build option.
        if (!resetn) begin
            s_nxt = '0;
            s_nxt.st = ST_IDLE;
            s_nxt.settle = 8'(`SETTLE_CYC);
            s_nxt.self_test = avb_present;
            s_nxt.swap_en = `SWAP_RST;
            s_nxt.gen_en = `GEN_RST;
            s_nxt.mask = `MASK_RST;
            s_nxt.gen_len = gen_min_size;
            s_nxt.awready = 1'b1;
            s_nxt.wready = 1'b1;
            s_nxt.arready = 1'b1;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    // Clock enable freezes everything, except that reset always lands.
    always_ff @(posedge clk) begin
        if (ce || !resetn) s_r <= s_nxt;
    end

    assign tx_data = s_r.tx_data;
    assign tx_valid = s_r.tx_valid;
    assign tx_last = s_r.tx_last;
    assign mgmt_rd_req = s_r.mgmt_rd_req;
    assign mgmt_wr_req = s_r.mgmt_wr_req;
    assign phy_bus_address = `PHY_ADDR;
    assign ptp_tx_req = s_r.ptp_tx_req;
    assign irq = s_r.irq;
    assign awready = s_r.awready;
    assign wready = s_r.wready;
    assign bresp = s_r.bresp;
    assign bvalid = s_r.bvalid;
    assign arready = s_r.arready;
    assign rdata = s_r.rdata;
    assign rresp = s_r.rresp;
    assign rvalid = s_r.rvalid;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_MODE_RESET: assert property (@(posedge clk) !$past(resetn) && resetn |-> s_r.self_test == avb_present)
        else $error("Mode after reset differs from build default.");
    AST_PTP_FIRST: assert property (@(posedge clk) disable iff (!resetn)
        $rose(s_r.st == ST_RUN) && s_r.self_test && avb_present |-> s_r.ptp_seen == `PTP_FRAMES)
        else $error("Pattern run began before both timing frames returned.");
    AST_GEN_IN_RUN: assert property (@(posedge clk) disable iff (!resetn)
        ce && tick && gen_go |-> s_r.st == ST_RUN && s_r.gen_en)
        else $error("Generator active outside the run state.");
    AST_GEN_TAIL: assert property (@(posedge clk) disable iff (!resetn)
        ce && tick && gen_go && s_r.gen_gap == 4'h0 && gen_last |-> gen_b == 8'h01 ##1 s_r.gen_gap == `IFG_TICKS)
        else $error("Generated frame did not end cleanly.");
    AST_SWAP_HEAD: assert property (@(posedge clk) disable iff (!resetn)
        ce && tick && s_r.swap_en && s_r.out_cnt < 4'h6 |=> s_r.tx_data == $past(s_r.sr[5][7:0]))
        else $error("Swapped header byte wrong.");
    AST_PASS: assert property (@(posedge clk) disable iff (!resetn)
        ce && tick && !s_r.swap_en |=> s_r.tx_data == $past(s_r.sr[11][7:0])
        && s_r.tx_valid == $past(s_r.sr[11][9]))
        else $error("Unswapped byte altered.");
    AST_PHY_SKIP: assert property (@(posedge clk) disable iff (!resetn)
        ce && s_r.st == ST_MDIO_WAIT && mgmt_rd_valid |=>
        s_r.mgmt_wr_req == ($past(mgmt_rd_data) != `PHY_NONE))
        else $error("PHY setup not skipped on all ones.");
    AST_PHY_ADDR: assert property (@(posedge clk) disable iff (!resetn)
        s_r.mgmt_rd_req |-> phy_bus_address == `PHY_ADDR ##1 s_r.st == ST_MDIO_WAIT || !ce)
        else $error("PHY probe at wrong address.");
    COV_RUN: cover property (@(posedge clk) disable iff (!resetn) $rose(s_r.st == ST_RUN));
    COV_FRAME: cover property (@(posedge clk) disable iff (!resetn) s_r.tx_valid && s_r.tx_last);
    COV_PTP: cover property (@(posedge clk) disable iff (!resetn) s_r.st == ST_PTP_WAIT ##1 s_r.st == ST_RUN);

endmodule // seq_top

`default_nettype wire

// ### seq_cfg.svh
// Address map, field positions, reset values and timing counts of the self-test sequencer.
`ifndef SEQ_CFG_SVH
`define SEQ_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_IRQ_STS 8'h08
`define OFF_IRQ_MASK 8'h0c
`define OFF_FRAMES 8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_SELF_TEST 0
`define CTRL_SWAP 1
`define CTRL_GEN 2
`define CTRL_RESTART 3
`define IRQ_PHY 0
`define IRQ_PTP 1
`define IRQ_FRAME 2

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define SWAP_RST 1'b1
`define GEN_RST 1'b1
`define MASK_RST 3'h0
`define PHY_ADDR 5'h07
`define PHY_NONE 16'hffff
`define PTP_FRAMES 2'h2
`define IFG_TICKS 4'hc
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ 125
`define SETTLE_NS 1000
`define SETTLE_CYC ((`SETTLE_NS * `CLK_MHZ + 999) / 1000)

`endif

// ### seq_pkg.sv
// Types shared by the self-test sequencer.
package seq_pkg;

    // Control states, Gray coded along the usual path.
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_MDIO_RD = 3'h1,
        ST_MDIO_WAIT = 3'h3,
        ST_PTP_REQ = 3'h2,
        ST_PTP_WAIT = 3'h6,
        ST_RUN = 3'h7
    } seq_state_t;

    // Whole state of the sequencer in one record.
    typedef struct packed {
        seq_state_t st;
        logic [7:0] settle;
        logic [1:0] ptp_sent;
        logic [1:0] ptp_seen;
        logic phy_absent;
        logic self_test;
        logic swap_en;
        logic gen_en;
        logic [2:0] mask;
        logic [2:0] irq_sts;
        logic irq;
        logic [10:0] gen_len;
        logic [10:0] gen_idx;
        logic [3:0] gen_gap;
        logic [17:0][9:0] sr;
        logic [3:0] out_cnt;
        logic [7:0] tx_data;
        logic tx_valid;
        logic tx_last;
        logic lk1;
        logic lk2;
        logic lk3;
        logic mgmt_rd_req;
        logic mgmt_wr_req;
        logic ptp_tx_req;
        logic [15:0] frames;
        logic awready;
        logic wready;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } seq_regs_t;

endpackage

// ### mac_model.sv
// Far-side model of the MAC example: loopback, management responder and timing-frame echo.
`timescale 1ns/1ns
`default_nettype none
module mac_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Mode: loop the transmit stream back, and answer slowly.
    input wire logic loop_on,
    input wire logic slow,
    // Bench injection used outside loopback.
    input wire logic [7:0] inj_data,
    input wire logic inj_valid,
    input wire logic inj_last,
    // Stream from and to the sequencer.
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_last,
    // Management and timing frames.
    input wire logic mgmt_rd_req,
    output logic mgmt_rd_valid,
    output logic [15:0] mgmt_rd_data,
    input wire logic ptp_tx_req,
    output logic ptp_rx_seen
);
    logic [7:0] lb_data; // Last byte seen on transmit.
    logic lb_valid, lb_last, mbusy;
    logic [5:0] gap, mcnt, pcnt;
    logic [1:0] pend; // Timing frames still to echo.
    logic fire;
    assign fire = (pend != 2'h0) && (pcnt == (slow ? 6'h28 : 6'h03));
    // Each byte is held until the next one; a stalled stream drops valid and scrambles data.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            {lb_data, lb_valid, lb_last, gap, mbusy, mcnt, mgmt_rd_valid, pend, pcnt, ptp_rx_seen} <= '0;
        end else begin
            if (tx_valid) begin
                {lb_data, lb_last, lb_valid, gap} <= {tx_data, tx_last, 1'b1, 6'h00};
            end else if (gap == 6'h14) begin
                lb_valid <= 1'b0;
            end else begin
                gap <= gap + 6'h01;
            end
            // A read is answered after a short or a long wait, never on the request edge.
            mgmt_rd_valid <= mbusy && (mcnt == (slow ? 6'h28 : 6'h04));
            mbusy <= mgmt_rd_req | (mbusy && !mgmt_rd_valid);
            mcnt <= mgmt_rd_req ? 6'h00 : mcnt + 6'h01;
            // Every requested timing frame comes back once.
            pend <= pend + {1'b0, ptp_tx_req} - {1'b0, fire};
            pcnt <= fire || pend == 2'h0 ? 6'h00 : pcnt + 6'h01;
            ptp_rx_seen <= fire;
        end
    end
    assign rx_data = loop_on ? (lb_valid ? lb_data : ~lb_data) : inj_data;
    assign rx_valid = loop_on ? lb_valid : inj_valid;
    assign rx_last = loop_on ? lb_last : inj_last;
    assign mgmt_rd_data = mgmt_rd_valid ? 16'hffff : 16'h0000;
endmodule // mac_model
`default_nettype wire

// ### seq_top_tb_top.sv
// Self-checking bench of the self-test sequencer.
`timescale 1ns/1ns
`default_nettype none
`include "seq_cfg.svh"
module seq_top_tb_top;
    logic clk = 0, resetn = 0, link_clk = 0, loop_on = 1, slow = 0, wr_seen = 0;
    logic [7:0] inj_data = 8'h00, rx_data, tx_data, awaddr = 8'h00, araddr = 8'h00;
    logic inj_valid = 0, inj_last = 0, rx_valid, rx_last, tx_valid, tx_last;
    logic mgmt_rd_req, mgmt_wr_req, mgmt_rd_valid, ptp_tx_req, ptp_rx_seen, irq;
    logic [4:0] phy_bus_address;
    logic [15:0] mgmt_rd_data;
    logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0, arvalid = 0, arready, rvalid, rready = 0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp, rs;
    logic [7:0] got [0:31], src [0:31];
    int fails = 0, compares = 0;
    always #4 clk = ~clk;
    // Link clock, 125 ns, drifting against the 8 ns clock.
    always begin
        #62 link_clk = 1;
        #63 link_clk = 0;
    end
    always @(posedge clk) if (mgmt_wr_req) wr_seen <= 1;
    seq_top #(.avb_present(1'b1), .gen_min_size(11'h003), .gen_max_size(11'h004)) seq_top_inst (
        .clk(clk), .resetn(resetn), .ce(1'b1), .link_clk(link_clk),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_last(rx_last),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
        .mgmt_rd_req(mgmt_rd_req), .mgmt_wr_req(mgmt_wr_req), .phy_bus_address(phy_bus_address),
        .mgmt_rd_valid(mgmt_rd_valid), .mgmt_rd_data(mgmt_rd_data), .ptp_tx_req(ptp_tx_req),
        .ptp_rx_seen(ptp_rx_seen), .irq(irq), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready));
    mac_model mac_model_inst (
        .clk(clk), .resetn(resetn), .loop_on(loop_on), .slow(slow), .inj_data(inj_data),
        .inj_valid(inj_valid), .inj_last(inj_last), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_last(tx_last), .rx_data(rx_data), .rx_valid(rx_valid), .rx_last(rx_last),
        .mgmt_rd_req(mgmt_rd_req), .mgmt_rd_valid(mgmt_rd_valid), .mgmt_rd_data(mgmt_rd_data),
        .ptp_tx_req(ptp_tx_req), .ptp_rx_seen(ptp_rx_seen));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic results;
        $display("Comparisons %0d, mismatches %0d.", compares, fails);
        if (fails == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    // A hang counts as a mismatch and ends the run.
    task automatic tmo(input string nm);
        chk(nm, 32'h1, 32'h0);
        results();
    endtask
    // Write: address and data offered together, each released when taken.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit ad, wd, bd;
        int n;
        ad = 0; wd = 0; bd = 0; n = 0;
        // Let an edge pass so a back-to-back call never reassigns a strobe in one step.
        @(posedge clk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (!bd && n < 200) begin
            @(posedge clk); n++;
            if (bvalid && ad && wd) begin bd = 1; bready <= 0; chk("bresp", er, bresp); end
            if (awready && !ad) begin ad = 1; awvalid <= 0; end
            if (wready && !wd) begin wd = 1; wvalid <= 0; end
        end
        if (!bd) tmo("write answer");
    endtask
    task automatic axi_rd(input logic [7:0] a);
        bit ad, dd;
        int n;
        ad = 0; dd = 0; n = 0;
        @(posedge clk);
        araddr <= a; arvalid <= 1; rready <= 1;
        while (!dd && n < 200) begin
            @(posedge clk); n++;
            if (rvalid && ad) begin dd = 1; rready <= 0; rd = rdata; rs = rresp; end
            if (arready && !ad) begin ad = 1; arvalid <= 0; end
        end
        if (!dd) tmo("read answer");
    endtask
    // Takes n bytes off the transmit stream, each when its valid pulse is sampled.
    task automatic collect(input int n);
        int k;
        for (int i = 0; i < n; i++) begin
            k = 0;
            do begin @(posedge clk); k++; end while (tx_valid !== 1'b1 && k < 4000);
            if (k >= 4000) tmo("transmit byte");
            got[i] = tx_data;
            if (i == n - 1) chk("tx_last", 1, tx_last);
        end
    endtask
    // Drives one byte per link tick, changed mid-tick so the sampling edge sees it settled.
    task automatic inject(input int n);
        for (int i = 0; i <= n; i++) begin
            @(negedge link_clk); @(posedge clk);
            inj_data <= (i < n) ? src[i] : ~src[n - 1];
            inj_valid <= (i < n);
            inj_last <= (i == n - 1);
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        axi_rd(`OFF_CTRL); chk("ctrl reset", 32'h7, rd);
        axi_rd(`OFF_IRQ_MASK); chk("mask reset", 32'h0, rd);
        chk("phy address", `PHY_ADDR, phy_bus_address);
    endtask
    // Probe, two timing frames, then two generated frames of growing length.
    task automatic t_self_test;
        for (int len = 3; len <= 4; len++) begin
            collect(14 + len);
            for (int j = 0; j < 14 + len; j++) begin
                src[j] = j < 5 || (j > 5 && j < 11) || j == 12 ? 8'h00 : j == 0 || j == 6 ? 8'h02 : 8'h00;
                if (j == 0 || j == 6) src[j] = 8'h02;
                if (j == 5) src[j] = 8'h01;
                if (j == 11) src[j] = 8'h02;
                if (j == 13) src[j] = len[7:0];
                if (j > 13) src[j] = 8'(14 + len - j);
                chk("generated byte", src[j], got[j]);
            end
        end
        axi_rd(`OFF_STATUS); chk("status after run", 32'haf, rd);
        axi_rd(`OFF_FRAMES); chk("frames generated", 32'h2, rd);
        chk("no phy write", 0, wr_seen);
    endtask
    // Directed frame through the address-swap path, with swap on and off.
    task automatic t_swap(input logic sw);
        for (int j = 0; j < 14; j++) src[j] = 8'(j + 1);
        fork
            inject(14);
            collect(14);
        join
        for (int j = 0; j < 14; j++)
            chk("looped byte", sw && j < 12 ? src[j < 6 ? j + 6 : j - 6] : src[j], got[j]);
    endtask
    // Restart re-probes the PHY; the probe event reaches irq only when unmasked.
    task automatic t_restart(input int k);
        int n;
        slow <= k[0];
        axi_wr(`OFF_IRQ_MASK, k ? 32'h7 : 32'h6, `RESP_OKAY);
        axi_wr(`OFF_CTRL, 32'h8, `RESP_OKAY);
        n = 0;
        do begin @(posedge clk); n++; end while (mgmt_rd_req !== 1'b1 && n < 400);
        if (n >= 400) tmo("re-probe");
        repeat (100) @(posedge clk);
        chk("irq raised", k[0], irq);
        axi_rd(`OFF_IRQ_STS); chk("probe event", 32'h1, rd);
        repeat (3) @(posedge clk);
        chk("irq cleared", 0, irq);
        axi_rd(`OFF_STATUS); chk("state run", 32'hf, rd & 32'hf);
    endtask
    task automatic t_refuse;
        axi_wr(8'h14, 32'h1, `RESP_SLVERR);
        axi_rd(8'h14); chk("unmapped data", 0, rd); chk("unmapped resp", `RESP_SLVERR, rs);
        axi_wr(`OFF_STATUS, 32'h0, `RESP_OKAY);
        axi_rd(`OFF_IRQ_MASK); chk("mask kept", 32'h7, rd);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1;
        t_reset();
        t_self_test();
        // Open the loop first, or the stopped generator's bytes would circle forever.
        loop_on <= 0;
        axi_wr(`OFF_CTRL, 32'h2, `RESP_OKAY);
        repeat (800) @(posedge clk);
        axi_rd(`OFF_IRQ_STS);
        t_swap(1);
        axi_wr(`OFF_CTRL, 32'h0, `RESP_OKAY);
        t_swap(0);
        axi_rd(`OFF_IRQ_STS);
        t_restart(0);
        t_restart(1);
        t_refuse();
        results();
    end
endmodule // seq_top_tb_top
`default_nettype wire
